// *** design/store_exec_pkg.sv ***
// Shared constants, encodings and carrier types for the store execution block.
package store_exec_pkg;

  // ==========================================================================
  // Instruction encoding
  // ==========================================================================
  localparam logic [5:0] OPC_HALF = 6'h2C;
  localparam logic [5:0] OPC_HALF_UPD = 6'h2D;
  localparam logic [5:0] OPC_EXTENDED = 6'h1F;
  localparam logic [9:0] XO_SINGLE_X = 10'h297;
  localparam logic [9:0] XO_HALF_X = 10'h197;
  localparam logic [9:0] XO_HALF_UX = 10'h1B7;
  localparam logic [9:0] XO_HALF_BRX = 10'h396;

  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int SRC_MSB = 25;
  localparam int SRC_LSB = 21;
  localparam int BASE_MSB = 20;
  localparam int BASE_LSB = 16;
  localparam int INDEX_MSB = 15;
  localparam int INDEX_LSB = 11;
  localparam int XO_MSB = 10;
  localparam int XO_LSB = 1;
  localparam int DISP_MSB = 15;
  localparam int DISP_LSB = 0;

  localparam logic [4:0] GPR_ZERO = 5'h00;

  // ==========================================================================
  // Double to single conversion thresholds (biased double exponent)
  // ==========================================================================
  localparam logic [10:0] EXP_NORM_MIN = 11'h381;
  localparam logic [10:0] EXP_DENORM_MIN = 11'h36A;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SINGLE_X,
    OP_HALF_D,
    OP_HALF_DU,
    OP_HALF_X,
    OP_HALF_UX,
    OP_HALF_BRX
  } store_op_e;

  typedef enum logic {
    SIZE_HALF,
    SIZE_WORD
  } store_size_e;

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] base_val;
    logic [31:0] index_val;
    logic [31:0] src_val;
    logic [63:0] fp_val;
  } issue_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    store_size_e size;
  } store_req_s;

  typedef struct packed {
    logic align_fault;
    logic dsi_fault;
  } store_resp_s;

  typedef struct packed {
    logic [4:0] idx;
    logic [31:0] value;
  } gpr_wb_s;

  typedef struct packed {
    logic illegal;
    logic align_fault;
    logic dsi_fault;
  } done_s;

endpackage

// *** design/fp_single_conv.sv ***
// Conversion of a double-precision register image to the single-precision store word.
`timescale 1ns/1ps
module fp_single_conv
  import store_exec_pkg::*;
(
  input wire logic [63:0] dbl,
  output logic [31:0] single
);

  logic [10:0] exp_biased;
  logic [52:0] mant_full;
  logic [52:0] mant_shifted;
  logic [10:0] shift_wide;

  assign exp_biased = dbl[62:52];
  assign mant_full = {1'b1, dbl[51:0]};
  assign shift_wide = EXP_NORM_MIN - exp_biased;
  assign mant_shifted = mant_full >> shift_wide[4:0];

  // Store conversion is pure bit selection, so it never rounds and never
  // touches the floating-point status; tiny values are denormalised by shifting.
  always_comb
  begin
    if (exp_biased < EXP_NORM_MIN && exp_biased >= EXP_DENORM_MIN)
    begin
      // The hidden one lands in the fraction field, so it is kept below bit 52.
      single = {dbl[63], 8'h00, mant_shifted[51:29]};
    end
    else
    begin
      single = {dbl[63:62], dbl[58:29]};
    end
  end

endmodule

// *** design/store_exec.sv ***
// Decode and execution of the single indexed and halfword store instructions.
//
// Function
// - Single store writes converted word to storage
// - Indexed address: base plus index, index if zero
// - Displacement address: sign-extended offset plus base
// - Halfword stores write source low halfword
// - Byte-reversed store swaps the two bytes
// - Update writes address back if base nonzero, faultless
// - Single store changes no status or condition
// - Halfword stores change no exception or condition
`timescale 1ns/1ps
module store_exec
  import store_exec_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic issue_valid,
  input wire issue_s issue,
  output logic issue_ready,
  output logic store_valid,
  output store_req_s store_req,
  input wire logic store_ack,
  input wire store_resp_s store_resp,
  output logic gpr_we,
  output gpr_wb_s gpr_wb,
  output logic done,
  output done_s done_info
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic store_op_e decode_op(input logic [31:0] instr);
    store_op_e op;
    op = OP_NONE;
    if (instr[OPC_MSB:OPC_LSB] == OPC_HALF)
    begin
      op = OP_HALF_D;
    end
    else if (instr[OPC_MSB:OPC_LSB] == OPC_HALF_UPD)
    begin
      op = OP_HALF_DU;
    end
    else if (instr[OPC_MSB:OPC_LSB] == OPC_EXTENDED)
    begin
      if (instr[XO_MSB:XO_LSB] == XO_SINGLE_X)
      begin
        op = OP_SINGLE_X;
      end
      else if (instr[XO_MSB:XO_LSB] == XO_HALF_X)
      begin
        op = OP_HALF_X;
      end
      else if (instr[XO_MSB:XO_LSB] == XO_HALF_UX)
      begin
        op = OP_HALF_UX;
      end
      else if (instr[XO_MSB:XO_LSB] == XO_HALF_BRX)
      begin
        op = OP_HALF_BRX;
      end
    end
    return op;
  endfunction

  // A zero base field means the value zero, not the contents of register 0.
  function automatic logic [31:0] ea_calc(input logic [4:0] base_field,
                                          input logic [31:0] base_val,
                                          input logic [31:0] offset);
    return (base_field == GPR_ZERO) ? offset : base_val + offset;
  endfunction

  function automatic logic is_update(input store_op_e op);
    return (op == OP_HALF_DU) || (op == OP_HALF_UX);
  endfunction

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Operand decode and address, data formation
  // ==========================================================================
  store_op_e op_in;
  logic [4:0] base_field_in;
  logic [31:0] disp_ext;
  logic [31:0] ea_index;
  logic [31:0] ea_disp;
  logic [31:0] single_word;
  logic [15:0] src_half;
  logic take;

  fp_single_conv conv_u (
    .dbl(issue.fp_val),
    .single(single_word)
  );

  assign op_in = decode_op(issue.instr);
  assign base_field_in = issue.instr[BASE_MSB:BASE_LSB];
  assign disp_ext = {{16{issue.instr[DISP_MSB]}}, issue.instr[DISP_MSB:DISP_LSB]};
  assign ea_index = ea_calc(base_field_in, issue.base_val, issue.index_val);
  assign ea_disp = ea_calc(base_field_in, issue.base_val, disp_ext);
  assign src_half = issue.src_val[15:0];
  assign take = issue_valid && issue_ready;

  // ==========================================================================
  // Execution state machine
  // ==========================================================================
  typedef enum logic {ST_IDLE, ST_STORE} state_e;

  state_e state_reg, state_next;
  store_op_e op_reg, op_next;
  logic [4:0] base_field_reg, base_field_next;
  logic issue_ready_reg, issue_ready_next;
  logic store_valid_reg, store_valid_next;
  store_req_s store_req_reg, store_req_next;
  logic gpr_we_reg, gpr_we_next;
  gpr_wb_s gpr_wb_reg, gpr_wb_next;
  logic done_reg, done_next;
  done_s done_info_reg, done_info_next;

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    base_field_next = base_field_reg;
    store_valid_next = store_valid_reg;
    store_req_next = store_req_reg;
    gpr_we_next = 1'b0;
    gpr_wb_next = gpr_wb_reg;
    done_next = 1'b0;
    done_info_next = done_info_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take)
        begin
          if (op_in == OP_NONE)
          begin
            done_next = 1'b1;
            done_info_next = '{illegal: 1'b1, align_fault: 1'b0, dsi_fault: 1'b0};
          end
          else
          begin
            state_next = ST_STORE;
            op_next = op_in;
            base_field_next = base_field_in;
            store_valid_next = 1'b1;
            store_req_next.size = SIZE_HALF;
            store_req_next.data = {16'h0000, src_half};
            if (op_in == OP_HALF_D || op_in == OP_HALF_DU)
            begin
              store_req_next.addr = ea_disp;
            end
            else
            begin
              store_req_next.addr = ea_index;
            end
            if (op_in == OP_SINGLE_X)
            begin
              store_req_next.size = SIZE_WORD;
              store_req_next.data = single_word;
            end
            else if (op_in == OP_HALF_BRX)
            begin
              store_req_next.data = {16'h0000, src_half[7:0], src_half[15:8]};
            end
          end
        end
      end
      ST_STORE:
      begin
        if (store_ack)
        begin
          state_next = ST_IDLE;
          store_valid_next = 1'b0;
          done_next = 1'b1;
          done_info_next = '{illegal: 1'b0, align_fault: store_resp.align_fault,
                             dsi_fault: store_resp.dsi_fault};
          // Only the base register can be written; status, exception and
          // condition registers have no write path out of this block.
          if (is_update(op_reg) && base_field_reg != GPR_ZERO &&
              !store_resp.align_fault && !store_resp.dsi_fault)
          begin
            gpr_we_next = 1'b1;
            gpr_wb_next = '{idx: base_field_reg, value: store_req_reg.addr};
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    issue_ready_next = (state_next == ST_IDLE);
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      base_field_reg <= GPR_ZERO;
      issue_ready_reg <= 1'b0;
      store_valid_reg <= 1'b0;
      store_req_reg <= '0;
      gpr_we_reg <= 1'b0;
      gpr_wb_reg <= '0;
      done_reg <= 1'b0;
      done_info_reg <= '0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      base_field_reg <= base_field_next;
      issue_ready_reg <= issue_ready_next;
      store_valid_reg <= store_valid_next;
      store_req_reg <= store_req_next;
      gpr_we_reg <= gpr_we_next;
      gpr_wb_reg <= gpr_wb_next;
      done_reg <= done_next;
      done_info_reg <= done_info_next;
    end
  end

  assign issue_ready = issue_ready_reg;
  assign store_valid = store_valid_reg;
  assign store_req = store_req_reg;
  assign gpr_we = gpr_we_reg;
  assign gpr_wb = gpr_wb_reg;
  assign done = done_reg;
  assign done_info = done_info_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Checks assume ce stays high across each checked window.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n || !ce);

  logic idx_form;
  logic ack_clean;
  assign idx_form = (op_in == OP_SINGLE_X) || (op_in == OP_HALF_X) ||
                    (op_in == OP_HALF_UX) || (op_in == OP_HALF_BRX);
  assign ack_clean = store_valid && store_ack && !store_resp.align_fault &&
                     !store_resp.dsi_fault;

  single_word_a: assert property (
    take && op_in == OP_SINGLE_X |=> store_valid && store_req.size == SIZE_WORD &&
      store_req.data[31] == $past(issue.fp_val[63]))
    else $error("single store did not issue a converted word");
  index_ea_a: assert property (
    take && idx_form |=> store_req.addr == ($past(base_field_in) == GPR_ZERO ?
      $past(issue.index_val) : $past(issue.base_val) + $past(issue.index_val)))
    else $error("indexed effective address wrong");
  disp_ea_a: assert property (
    take && (op_in == OP_HALF_D || op_in == OP_HALF_DU) |=> store_req.addr ==
      ($past(base_field_in) == GPR_ZERO ? $past(disp_ext) :
      $past(issue.base_val) + $past(disp_ext)))
    else $error("displacement effective address wrong");
  half_data_a: assert property (
    take && (op_in == OP_HALF_D || op_in == OP_HALF_DU || op_in == OP_HALF_X ||
      op_in == OP_HALF_UX) |=> store_req.size == SIZE_HALF &&
      store_req.data[15:0] == $past(issue.src_val[15:0]))
    else $error("halfword data wrong");
  rev_data_a: assert property (
    take && op_in == OP_HALF_BRX |=> store_req.data[15:8] == $past(issue.src_val[7:0])
      && store_req.data[7:0] == $past(issue.src_val[15:8]))
    else $error("byte-reversed data wrong");
  wb_update_a: assert property (
    ack_clean && is_update(op_reg) && base_field_reg != GPR_ZERO |=> gpr_we &&
      gpr_wb.value == $past(store_req.addr) && gpr_wb.idx == $past(base_field_reg))
    else $error("update form failed to write the address back");
  wb_fault_a: assert property (
    store_valid && store_ack && (store_resp.align_fault || store_resp.dsi_fault)
      |=> !gpr_we ##1 !gpr_we)
    else $error("address written back after a fault");
  single_nowb_a: assert property (
    state_reg == ST_STORE && op_reg == OP_SINGLE_X |=> !gpr_we)
    else $error("single store wrote a register");
  half_nowb_a: assert property (
    gpr_we |-> is_update(op_reg) && gpr_wb.idx != GPR_ZERO && done &&
      !done_info.illegal)
    else $error("halfword store wrote a register it must not");
  illegal_a: assert property (
    take && op_in == OP_NONE |=> done && done_info.illegal && !store_valid && issue_ready)
    else $error("undecoded instruction not reported");

  single_c: cover property (take && op_in == OP_SINGLE_X ##[1:20] store_ack);
  update_c: cover property (ack_clean && is_update(op_reg) ##1 gpr_we);
  fault_c: cover property (store_valid && store_ack && store_resp.dsi_fault);
  illegal_c: cover property (take && op_in == OP_NONE);

endmodule

// *** verif/storage_model.sv ***
// Behavioural storage partner that acknowledges store requests.
`timescale 1ns/1ps
module storage_model
  import store_exec_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic store_valid,
  input wire logic [1:0] delay,
  input wire logic fail_align,
  input wire logic fail_dsi,
  output logic store_ack,
  output store_resp_s store_resp
);
  // ==========================================================================
  // Acknowledge after a chosen number of wait cycles
  // ==========================================================================
  logic [1:0] wait_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_ack <= 1'h0;
      wait_reg <= 2'h0;
    end
    else
    begin
      store_ack <= 1'h0;
      if (store_valid && !store_ack)
      begin
        if (wait_reg == delay)
        begin
          store_ack <= 1'h1;
          wait_reg <= 2'h0;
        end
        else
          wait_reg <= wait_reg + 2'h1;
      end
    end
  end

  // Outside the acknowledge cycle the response shows the inverse, so stale use is caught.
  always_comb
  begin
    store_resp.align_fault = store_ack ? fail_align : ~fail_align;
    store_resp.dsi_fault = store_ack ? fail_dsi : ~fail_dsi;
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking testbench for the store execution block.
`timescale 1ns/1ps
module testbench;
  import store_exec_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic issue_valid = 1'h0;
  issue_s issue = '0;
  logic issue_ready;
  logic store_valid;
  logic store_ack;
  logic gpr_we;
  logic done;
  store_req_s store_req;
  store_resp_s store_resp;
  gpr_wb_s gpr_wb;
  done_s done_info;
  logic [1:0] delay = 2'h0;
  logic ce = 1'h1;
  logic f_align = 1'h0;
  logic f_dsi = 1'h0;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 41441;
  int cycles = 0;

  always #50 clock = ~clock;

  store_exec dut (.clock(clock), .rst_n(rst_n), .ce(ce), .issue_valid(issue_valid),
    .issue(issue), .issue_ready(issue_ready), .store_valid(store_valid),
    .store_req(store_req), .store_ack(store_ack), .store_resp(store_resp),
    .gpr_we(gpr_we), .gpr_wb(gpr_wb), .done(done), .done_info(done_info));

  storage_model partner (.clock(clock), .rst_n(rst_n), .store_valid(store_valid),
    .delay(delay), .fail_align(f_align), .fail_dsi(f_dsi), .store_ack(store_ack),
    .store_resp(store_resp));

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      $display("unexpected hang: cycle limit reached");
      summarize();
    end
  end

  // ==========================================================================
  // Reference model and one instruction
  // ==========================================================================
  task automatic exec(input logic [31:0] ins, input logic [31:0] b, input logic [31:0] x,
    input logic [31:0] s, input logic [63:0] fp, input bit hold);
    int k;
    logic [52:0] mf;
    logic [31:0] ea;
    logic [31:0] dat;
    logic wb;
    logic got_req;
    k = 0;
    if (ins[31:26] == 6'h2C) k = 2;
    if (ins[31:26] == 6'h2D) k = 3;
    if (ins[31:26] == 6'h1F && ins[10:1] == 10'h297) k = 1;
    if (ins[31:26] == 6'h1F && ins[10:1] == 10'h197) k = 4;
    if (ins[31:26] == 6'h1F && ins[10:1] == 10'h1B7) k = 5;
    if (ins[31:26] == 6'h1F && ins[10:1] == 10'h396) k = 6;
    ea = (ins[20:16] == 5'h00) ? 32'h0 : b;
    ea = ea + ((k == 2 || k == 3) ? {{16{ins[15]}}, ins[15:0]} : x);
    dat = {16'h0, s[15:0]};
    if (k == 6) dat = {16'h0, s[7:0], s[15:8]};
    if (k == 1) dat = {fp[63:62], fp[58:29]};
    // Biased exponents just below the single normal range denormalise the word.
    mf = {1'h1, fp[51:0]} >> (EXP_NORM_MIN - fp[62:52]);
    if (k == 1 && fp[62:52] >= EXP_DENORM_MIN && fp[62:52] < EXP_NORM_MIN)
      dat = {fp[63], 8'h00, mf[51:29]};
    wb = (k == 3 || k == 5) && ins[20:16] != 5'h00 && !f_align && !f_dsi;
    got_req = 1'h0;
    @(negedge clock);
    issue_valid = 1'h1;
    issue = '{ins, b, x, s, fp};
    if (hold)
    begin
      ce = 1'h0;
      repeat (3) @(negedge clock);
      check("frozen", 32'({store_valid, done, issue_ready}), 32'h1);
      ce = 1'h1;
    end
    while (issue_ready !== 1'h1) @(negedge clock);
    @(negedge clock);
    issue_valid = 1'h0;
    for (int i = 0; i < 40; i++)
    begin
      if (store_valid === 1'h1 && !got_req)
      begin
        got_req = 1'h1;
        check("ready", 32'(issue_ready), 32'h0);
        check("address", store_req.addr, ea);
        check("data", store_req.data, dat);
        check("size", 32'(store_req.size), 32'(k == 1));
      end
      if (done === 1'h1)
        break;
      @(negedge clock);
    end
    check("done", 32'(done), 32'h1);
    check("illegal", 32'(done_info.illegal), 32'(k == 0));
    check("request", 32'(got_req), 32'(k != 0));
    check("align", 32'(done_info.align_fault), 32'(k != 0 && f_align));
    check("dsi", 32'(done_info.dsi_fault), 32'(k != 0 && f_dsi));
    check("writeback", 32'(gpr_we), 32'(wb));
    if (wb)
    begin
      check("wb index", 32'(gpr_wb.idx), 32'(ins[20:16]));
      check("wb value", gpr_wb.value, ea);
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    logic [31:0] ins;
    logic [5:0] opc [0:6];
    logic [9:0] xo [0:6];
    logic [63:0] fp;
    opc = '{6'h2C, 6'h2D, 6'h1F, 6'h1F, 6'h1F, 6'h1F, 6'h1F};
    xo = '{10'h000, 10'h000, 10'h297, 10'h197, 10'h1B7, 10'h396, 10'h397};
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_n = 1'h1;
    exec({6'h1F, 5'h06, 5'h00, 5'h04, 10'h297, 1'h0}, 32'h0, 32'h1000, 32'h0,
      64'h48656C6C6F20776F, 1'h0);
    $display("single store example done");
    for (int i = 0; i < 70; i++)
    begin
      ins = $random(seed);
      ins[31:26] = (i % 14 == 13) ? 6'h2E : opc[i % 7];
      if (ins[31:26] == 6'h1F) ins[10:1] = xo[i % 7];
      if (i % 3 == 0) ins[20:16] = 5'h00;
      delay = 2'($random(seed));
      f_align = (i % 10 == 4);
      f_dsi = (i % 10 == 8);
      fp = {$random(seed), $random(seed)};
      if (i % 2 == 0) fp[62:52] = 11'h369 + 11'(i % 25);
      exec(ins, $random(seed), $random(seed), $random(seed), fp, i % 9 == 4);
    end
    $display("opcode sweep done");
    exec({6'h1F, 5'h01, 5'h03, 5'h02, 10'h297, 1'h0}, 32'h2000, 32'h10, 32'h0,
      64'h37A8000000000000, 1'h1);
    $display("denormal single store done");
    summarize();
  end
endmodule
